// ===== logic/tne_numeric_entry.sv
// Purpose: Touch-panel numeric entry controller with AXI4-Lite registers.
// Assumes: Key and thumbwheel events come from scanner logic on aclk.
// Notes:   Values are kept as right-aligned nibble strings (BCD or hex).
//
// Overview of operation
// [R1] Switches 227-230 and 255 decode as menu, up, down, buzzer stop, confirm.
// [R2] System-key presses are never passed to the host as switch bits.
// [R3] Buzzer-stop key silences a sounding buzzer.
// [R4] Digits show in the active field; confirm stores and reports together.
// [R5] At most eight digits, seven with a minus sign, decimal or hex.
// [R6] Decimal without sign accepts 0 to 99999999.
// [R7] Decimal with sign accepts -9999999..+99999999, negatives seven digits.
// [R8] Thumbwheel with sign limits both polarities to seven digits; the wheel itself still steps all eight digits.
// [R9] At most seven fraction digits, six when negative.
// [R10] Hex attribute accepts unsigned values up to eight digits.
// [R11] Enabled limit check drops out-of-range values and reverts the field; wheel steps are stored unchecked.
// [R12] Limit check applies only with direct connection.
// [R13] Up to 50 entry fields per screen.
// [R14] Confirm key commits the shown value to memory and host.
// [R15] Numeric cursor keys choose which field takes entry.
// [R16] Thumbwheel steps digits; each change stored and reported at once; the wheel acts only with direct connection.
// [R17] A child screen never acts as an entry screen.
// [R18] On an entry screen switches 227-255 are never notified.
// [R19] Home moves to the field with the least X+Y sum.
// [R20] Digits beyond the allowed count are ignored.
`timescale 1ns/1ps
`include "tne_defines.svh"

module tne_numeric_entry
#(
    parameter int NUM_FIELDS = 50 // [R13]
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic key_valid,
    input wire logic [7:0] key_num,
    input wire logic wheel_valid,
    input wire logic wheel_up,
    input wire logic [2:0] wheel_digit,
    output logic sw_notify_valid,
    output logic [7:0] sw_notify_num,
    output logic menu_req,
    output logic buzzer_on,
    output logic entry_valid,
    output logic [5:0] entry_field,
    output logic [31:0] entry_value,
    output logic entry_neg
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    tne_pkg::tne_regs_t r, n;
    logic [31:0] mem [0:NUM_FIELDS-1];
    logic [15:0] xy [0:NUM_FIELDS-1];
    logic [5:0] last_idx;

    // Signed-magnitude a <= b on nibble strings of equal alignment
    function automatic logic val_le(input logic an, input logic [31:0] a,
                                    input logic bn, input logic [31:0] b);
        val_le = (an != bn) ? an : (an ? (a >= b) : (a <= b));
    endfunction

    // Ring step over the defined fields
    function automatic logic [5:0] step(input logic [5:0] c,
                                        input logic [5:0] last,
                                        input logic fwd);
        step = fwd ? ((c >= last) ? 6'h00 : c + 6'h01)
                   : ((c == 6'h00 || c > last) ? last : c - 6'h01);
    endfunction

    assign last_idx = r.field_cnt - 6'h01;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Key events arriving while the home scan or the limit check runs are
    // dropped; both take at most NUM_FIELDS cycles, far below key rates.
    always_comb
    begin
        logic entry_scr, is_sys, hex, thumb, sign_on, lim_ok, neg_lim, clr;
        logic [3:0] maxd, nib, top, digit;
        logic [2:0] maxf;
        logic [31:0] v;
        n = r;
        n.menu = 1'b0;
        n.notify = 1'b0;
        n.rpt = 1'b0;
        n.mem_we = 1'b0;
        n.xy_we = 1'b0;
        clr = 1'b0;
        hex = r.ctrl[`TNE_CB_HEX];
        thumb = r.ctrl[`TNE_CB_THUMB];
        sign_on = r.ctrl[`TNE_CB_SIGN] & ~hex; // [R10]
        entry_scr = r.ctrl[`TNE_CB_ENTRY] & ~r.ctrl[`TNE_CB_CHILD]; // [R17]
        is_sys = (key_num >= `TNE_K_MENU && key_num <= `TNE_K_BUZZ) ||
                 key_num == `TNE_K_CONFIRM; // [R1]
        neg_lim = r.neg | (thumb & sign_on); // [R8]
        maxd = (hex || !neg_lim) ? `TNE_MAX_DIG : `TNE_MAX_DIG_NEG; // [R5]
        maxf = r.neg ? `TNE_MAX_FRAC_NEG : `TNE_MAX_FRAC; // [R9]
        digit = (key_num >= `TNE_K_DA) ? 4'hA + 4'(key_num - `TNE_K_DA)
                                       : 4'(key_num - `TNE_K_D0);
        lim_ok = val_le(r.ctrl[`TNE_CB_LONEG], r.lower, r.neg, r.pend) &&
                 val_le(r.neg, r.pend, r.ctrl[`TNE_CB_UPNEG], r.upper);
        v = mem[r.cur];
        nib = v[{wheel_digit, 2'b00} +: 4];
        top = hex ? 4'hF : 4'h9;

        // Touch switch and thumbwheel handling
        case (r.state)
            tne_pkg::ST_IDLE:
            begin
                if (key_valid)
                begin
                    // Silent for system keys, and 227-255 on entry screens
                    if (!is_sys && !(entry_scr && key_num >= `TNE_K_MENU))
                    begin
                        n.notify = 1'b1; // [R2] [R18]
                        n.notify_num = key_num;
                    end
                    if (key_num == `TNE_K_MENU) n.menu = 1'b1; // [R1]
                    else if (key_num == `TNE_K_BUZZ) n.buzzer = 1'b0; // [R3]
                    else if (!entry_scr) n.state = tne_pkg::ST_IDLE;
                    else if (key_num == `TNE_K_CONFIRM)
                        n.state = tne_pkg::ST_CHECK; // [R14]
                    else if (key_num >= `TNE_K_D0 && key_num <= `TNE_K_DF)
                    begin
                        // Hex digits only under the hex attribute
                        if ((hex || key_num <= `TNE_K_D9) &&
                            r.ndig < maxd &&
                            !(r.point && r.nfrac >= maxf)) // [R20] [R9]
                        begin
                            n.pend = {r.pend[27:0], digit}; // [R4] [R6]
                            n.ndig = r.ndig + 4'h1;
                            if (r.point)
                                n.nfrac = r.nfrac + 3'h1;
                        end
                    end
                    else if (key_num == `TNE_K_CLR)
                        clr = 1'b1;
                    else if (key_num == `TNE_K_SIGN)
                    begin
                        // Minus refused when the digits already need eight or the fraction already needs seven
                        if (sign_on && (r.neg || (r.ndig <= `TNE_MAX_DIG_NEG
                            && r.nfrac <= `TNE_MAX_FRAC_NEG)))
                            n.neg = ~r.neg; // [R7]
                    end
                    else if (key_num == `TNE_K_POINT)
                    begin
                        if (!hex)
                            n.point = 1'b1;
                    end
                    else if (key_num == `TNE_K_HOME)
                    begin
                        n.state = tne_pkg::ST_HOME; // [R19]
                        n.scan = 6'h00;
                        n.best = 6'h00;
                        n.best_sum = 16'hFFFF;
                    end
                    else if (key_num >= `TNE_K_SYSUP)
                    begin
                        // Cursor keys; moving abandons the pending value
                        n.cur = step(r.cur, last_idx,
                                     key_num == `TNE_K_SYSDN ||
                                     key_num == `TNE_K_DN ||
                                     key_num == `TNE_K_RIGHT); // [R15]
                        clr = 1'b1;
                    end
                end
                else if (wheel_valid && entry_scr && thumb &&
                         r.ctrl[`TNE_CB_DIRECT])
                begin
                    // Wrap each digit within its own radix
                    if (wheel_up)
                        nib = (nib >= top) ? 4'h0 : nib + 4'h1;
                    else
                        nib = (nib == 4'h0) ? top : nib - 4'h1;
                    v[{wheel_digit, 2'b00} +: 4] = nib;
                    n.mem_we = 1'b1; // [R16]
                    n.mem_addr = r.cur;
                    n.mem_wdata = v;
                    n.rpt = 1'b1;
                    n.rpt_field = r.cur;
                    n.rpt_value = v;
                    n.rpt_neg = 1'b0;
                end
            end
            tne_pkg::ST_HOME:
            begin
                // Linear scan keeps area small; ties keep the first field
                if (xy[r.scan] < r.best_sum)
                begin
                    n.best_sum = xy[r.scan];
                    n.best = r.scan;
                end
                if (r.scan >= last_idx)
                begin
                    n.cur = (xy[r.scan] < r.best_sum) ? r.scan : r.best;
                    n.state = tne_pkg::ST_IDLE; // [R19]
                end
                else
                    n.scan = r.scan + 6'h01;
            end
            tne_pkg::ST_CHECK:
            begin
                if (!(r.ctrl[`TNE_CB_LIMIT] && r.ctrl[`TNE_CB_DIRECT]) ||
                    lim_ok) // [R11] [R12]
                begin
                    n.mem_we = 1'b1; // [R4] [R14]
                    n.mem_addr = r.cur;
                    n.mem_wdata = r.pend;
                    n.rpt = 1'b1;
                    n.rpt_field = r.cur;
                    n.rpt_value = r.pend;
                    n.rpt_neg = r.neg;
                end
                // Either way the entry is cleared and the stored value shows
                clr = 1'b1; // [R11]
                n.state = tne_pkg::ST_IDLE;
            end
            default:
                n.state = tne_pkg::ST_IDLE;
        endcase
        // Drop the pending entry
        if (clr)
        begin
            n.pend = 32'h0000_0000;
            n.ndig = 4'h0;
            n.nfrac = 3'h0;
            n.point = 1'b0;
            n.neg = 1'b0;
        end

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && r.awready)
        begin
            n.aw_ok = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready)
        begin
            n.w_ok = 1'b1;
            n.wdata = s_axi_wdata;
        end
        if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
        if (r.aw_ok && r.w_ok && !r.bvalid)
        begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `TNE_RESP_OKAY;
            // Byte strobes ignored: every register is written whole
            if (r.aw_addr == `TNE_OFS_CTRL)
            begin
                n.ctrl = r.wdata[`TNE_CTRL_W-1:0];
                if (r.wdata[`TNE_CNT_LSB +: 6] != 6'h00 &&
                    r.wdata[`TNE_CNT_LSB +: 6] <= 6'(NUM_FIELDS))
                    n.field_cnt = r.wdata[`TNE_CNT_LSB +: 6]; // [R13]
            end
            else if (r.aw_addr == `TNE_OFS_UPPER) n.upper = r.wdata;
            else if (r.aw_addr == `TNE_OFS_LOWER) n.lower = r.wdata;
            else if (r.aw_addr == `TNE_OFS_SEL)
                n.sel = (r.wdata[5:0] > last_idx) ? last_idx : r.wdata[5:0];
            else if (r.aw_addr == `TNE_OFS_DATA && !n.mem_we)
            begin
                n.mem_we = 1'b1;
                n.mem_addr = r.sel;
                n.mem_wdata = r.wdata;
            end
            else if (r.aw_addr == `TNE_OFS_XY)
            begin
                n.xy_we = 1'b1;
                n.xy_wdata = r.wdata[15:0];
            end
            else if (r.aw_addr == `TNE_OFS_BUZZ)
            begin
                // Set wins over a same-cycle buzzer-stop key
                if (r.wdata[0])
                    n.buzzer = 1'b1;
            end
            else if (r.aw_addr != `TNE_OFS_STATUS &&
                     r.aw_addr != `TNE_OFS_PEND)
                n.bresp = `TNE_RESP_SLVERR;
        end

        // AXI4-Lite read: one outstanding, SLVERR on unmapped addresses
        if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
        if (s_axi_arvalid && r.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = `TNE_RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if (s_axi_araddr == `TNE_OFS_CTRL)
            begin
                n.rdata[`TNE_CTRL_W-1:0] = r.ctrl;
                n.rdata[`TNE_CNT_LSB +: 6] = r.field_cnt;
            end
            else if (s_axi_araddr == `TNE_OFS_STATUS)
                n.rdata = {4'h0, r.cur, 2'h0, r.state, r.buzzer,
                           r.point, r.neg, r.nfrac, 1'b0, r.ndig, 6'h00};
            else if (s_axi_araddr == `TNE_OFS_UPPER) n.rdata = r.upper;
            else if (s_axi_araddr == `TNE_OFS_LOWER) n.rdata = r.lower;
            else if (s_axi_araddr == `TNE_OFS_PEND) n.rdata = r.pend;
            else if (s_axi_araddr == `TNE_OFS_SEL) n.rdata[5:0] = r.sel;
            else if (s_axi_araddr == `TNE_OFS_DATA) n.rdata = mem[r.sel];
            else if (s_axi_araddr == `TNE_OFS_XY) n.rdata[15:0] = xy[r.sel];
            else if (s_axi_araddr == `TNE_OFS_BUZZ) n.rdata[0] = r.buzzer;
            else
                n.rresp = `TNE_RESP_SLVERR;
        end
        n.awready = ~n.aw_ok;
        n.wready = ~n.w_ok;
        n.arready = ~n.rvalid;
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
            r.state <= tne_pkg::ST_IDLE;
            r.ctrl <= `TNE_CTRL_RST;
            r.field_cnt <= `TNE_CNT_RST;
        end
        else
            r <= n;
    end

    // Field tables take the registered write one cycle after the event
    always_ff @(posedge aclk)
    begin
        if (r.mem_we)
            mem[r.mem_addr] <= r.mem_wdata;
        if (r.xy_we)
            xy[r.sel] <= r.xy_wdata;
    end

    // Outputs straight from the state register
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign sw_notify_valid = r.notify;
    assign sw_notify_num = r.notify_num;
    assign menu_req = r.menu;
    assign buzzer_on = r.buzzer;
    assign entry_valid = r.rpt;
    assign entry_field = r.rpt_field;
    assign entry_value = r.rpt_value;
    assign entry_neg = r.rpt_neg;

endmodule

// ===== logic/tne_defines.svh
// Purpose: Offsets, fields, reset values and key codes of the entry block.
// Assumes: 32-bit AXI4-Lite register words, byte addresses.
// Notes:   Definitions only.
`ifndef TNE_DEFINES_SVH
`define TNE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TNE_OFS_CTRL 8'h00
`define TNE_OFS_STATUS 8'h04
`define TNE_OFS_UPPER 8'h08
`define TNE_OFS_LOWER 8'h0C
`define TNE_OFS_PEND 8'h10
`define TNE_OFS_SEL 8'h14
`define TNE_OFS_DATA 8'h18
`define TNE_OFS_XY 8'h1C
`define TNE_OFS_BUZZ 8'h20

// ----------------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------------
`define TNE_CB_ENTRY 0
`define TNE_CB_HEX 1
`define TNE_CB_SIGN 2
`define TNE_CB_LIMIT 3
`define TNE_CB_DIRECT 4
`define TNE_CB_CHILD 5
`define TNE_CB_THUMB 6
`define TNE_CB_UPNEG 7
`define TNE_CB_LONEG 8
`define TNE_CTRL_W 9
`define TNE_CNT_LSB 16
`define TNE_CTRL_RST 9'h000
`define TNE_CNT_RST 6'h01

// ----------------------------------------------------------------------
// Touch switch numbers
// ----------------------------------------------------------------------
`define TNE_K_MENU 8'hE3
`define TNE_K_SYSUP 8'hE4
`define TNE_K_SYSDN 8'hE5
`define TNE_K_BUZZ 8'hE6
`define TNE_K_D0 8'hE7
`define TNE_K_D9 8'hF0
`define TNE_K_DA 8'hF1
`define TNE_K_DF 8'hF6
`define TNE_K_CLR 8'hF7
`define TNE_K_SIGN 8'hF8
`define TNE_K_POINT 8'hF9
`define TNE_K_HOME 8'hFA
`define TNE_K_DN 8'hFC
`define TNE_K_RIGHT 8'hFE
`define TNE_K_CONFIRM 8'hFF

// ----------------------------------------------------------------------
// Digit limits and responses
// ----------------------------------------------------------------------
`define TNE_MAX_DIG 4'h8
`define TNE_MAX_DIG_NEG 4'h7
`define TNE_MAX_FRAC 3'h7
`define TNE_MAX_FRAC_NEG 3'h6
`define TNE_RESP_OKAY 2'h0
`define TNE_RESP_SLVERR 2'h2

`endif

// ===== logic/tne_pkg.sv
// Purpose: Types of the numeric entry controller.
// Assumes: Field index fits six bits (up to 64 fields).
// Notes:   Constants live in tne_defines.svh.
package tne_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_HOME = 3'b010,
        ST_CHECK = 3'b100
    } tne_state_t;

    typedef struct packed {
        tne_state_t state;
        logic [8:0] ctrl;
        logic [5:0] field_cnt;
        logic [31:0] upper;
        logic [31:0] lower;
        logic [5:0] sel;
        logic [5:0] cur;
        logic [31:0] pend;
        logic [3:0] ndig;
        logic [2:0] nfrac;
        logic point;
        logic neg;
        logic buzzer;
        logic [5:0] scan;
        logic [5:0] best;
        logic [15:0] best_sum;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic awready;
        logic w_ok;
        logic [31:0] wdata;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic menu;
        logic notify;
        logic [7:0] notify_num;
        logic rpt;
        logic [5:0] rpt_field;
        logic [31:0] rpt_value;
        logic rpt_neg;
        logic mem_we;
        logic [5:0] mem_addr;
        logic [31:0] mem_wdata;
        logic xy_we;
        logic [15:0] xy_wdata;
    } tne_regs_t;

endpackage

// ===== sim/tne_host_model.sv
// Purpose: Host side model that collects value and switch reports.
// Assumes: Reports are single-cycle pulses on aclk.
// Notes: The bench pops the queues and compares them with its own model.
`timescale 1ns/1ps
module tne_host_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic entry_valid,
    input wire logic [5:0] entry_field,
    input wire logic [31:0] entry_value,
    input wire logic entry_neg,
    input wire logic sw_notify_valid,
    input wire logic [7:0] sw_notify_num
);
    logic [38:0] rep_q[$];
    logic [7:0] ntf_q[$];
    // Take every report at its pulse; nothing is acknowledged back
    always @(posedge aclk)
    begin
        if (aresetn && entry_valid)
            rep_q.push_back({entry_neg, entry_field, entry_value});
        if (aresetn && sw_notify_valid)
            ntf_q.push_back(sw_notify_num);
    end
endmodule

// ===== sim/tne_entry_monitor.sv
// Purpose: Port-level checks of key decode, reports and register bus.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached to the design by bind below.
`timescale 1ns/1ps
`include "tne_defines.svh"
module tne_entry_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic key_valid,
    input wire logic [7:0] key_num,
    input wire logic wheel_valid,
    input wire logic sw_notify_valid,
    input wire logic [7:0] sw_notify_num,
    input wire logic menu_req,
    input wire logic entry_valid,
    input wire logic [31:0] entry_value,
    input wire logic entry_neg,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_arready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers that wait for the master
    sequence s_wait_b; s_axi_bvalid && !s_axi_bready; endsequence
    sequence s_wait_r; s_axi_rvalid && !s_axi_rready; endsequence
    a_menu_cause: assert property (menu_req |->
        $past(key_valid && key_num == `TNE_K_MENU)) else $error("menu");
    a_sys_silent: assert property (key_valid && (key_num inside
        {[`TNE_K_MENU:`TNE_K_BUZZ], `TNE_K_CONFIRM}) |=> !sw_notify_valid)
        else $error("system key notified");
    a_notify_cause: assert property (sw_notify_valid |->
        $past(key_valid) && sw_notify_num == $past(key_num))
        else $error("notify without key");
    a_report_cause: assert property (entry_valid |->
        $past(key_valid && key_num == `TNE_K_CONFIRM, 2) || $past(wheel_valid))
        else $error("report without cause");
    a_neg_digits: assert property (entry_valid && entry_neg |->
        entry_value[31:28] == 4'h0) else $error("negative too long");
    a_wr_hold: assert property (s_wait_b |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    a_rd_hold: assert property (s_wait_r |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read");
endmodule
bind tne_numeric_entry tne_entry_monitor u_tne_entry_monitor (.*);

// ===== sim/tne_numeric_entry_tb_top.sv
// Purpose: Self-checking bench of the numeric entry controller.
// Assumes: Field count 1, so every report names field 0.
// Notes: Digit model is a nibble shift with a digit limit.
`timescale 1ns/1ps
`include "tne_defines.svh"
module tne_numeric_entry_tb_top;
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
    logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic key_valid = '0, wheel_valid = '0, wheel_up = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, key_num = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, wheel_digit = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, entry_value, ev, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sw_notify_valid, menu_req, buzzer_on;
    logic entry_valid, entry_neg;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] sw_notify_num;
    logic [5:0] entry_field;
    logic [38:0] exp_q[$];
    logic [7:0] ntf_q[$];
    int fails = 0, compares = 0, cyc = 0, nd = 0, lim = 8, hx = 0, menus = 0;
    tne_numeric_entry #(.NUM_FIELDS(50)) u_tne_numeric_entry (.*);
    tne_host_model u_tne_host_model (.*);
    // Free-running clock and a cycle ceiling against hangs
    always #20 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        menus <= menus + int'(menu_req);
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [38:0] got, input logic [38:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Readies come together; the answer is taken late to test hold
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // Gaps after each event let the confirm check finish
    task automatic key(input logic [7:0] n);
        @(posedge aclk);
        key_valid <= 1'h1;
        key_num <= n;
        @(posedge aclk);
        key_valid <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic wheel(input logic u, input logic [2:0] g);
        @(posedge aclk);
        wheel_valid <= 1'h1;
        wheel_up <= u;
        wheel_digit <= g;
        @(posedge aclk);
        wheel_valid <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic dig(input int d);
        key(d < 10 ? `TNE_K_D0 + 8'(d) : `TNE_K_DA + 8'(d - 10));
        if (nd < lim && (hx != 0 || d < 10))
        begin
            ev = {ev[27:0], 4'(d)};
            nd++;
        end
    endtask
    task automatic conf(input logic ok, input logic ng);
        key(`TNE_K_CONFIRM);
        if (ok) exp_q.push_back({ng, 6'h00, ev});
        ev = '0;
        nd = 0;
    endtask
    task automatic drain();
        chk(39'(u_tne_host_model.rep_q.size()), 39'(exp_q.size()));
        chk(39'(u_tne_host_model.ntf_q.size()), 39'(ntf_q.size()));
        while (exp_q.size() > 0 && u_tne_host_model.rep_q.size() > 0)
            chk(u_tne_host_model.rep_q.pop_front(), exp_q.pop_front());
        while (ntf_q.size() > 0 && u_tne_host_model.ntf_q.size() > 0)
            chk(39'(u_tne_host_model.ntf_q.pop_front()),
                39'(ntf_q.pop_front()));
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(32'h9E926E92));
        ev = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(`TNE_OFS_CTRL);
        chk(39'(rd), 39'({`TNE_CNT_RST, 7'h00, `TNE_CTRL_RST}));
        rdr(8'h40);
        chk(39'(rr), 39'(`TNE_RESP_SLVERR));
        wr(`TNE_OFS_CTRL, 32'h0001_0021);
        chk(39'(rr), 39'(`TNE_RESP_OKAY));
        key(8'hF0);
        ntf_q.push_back(8'hF0);
        key(`TNE_K_SYSUP);
        drain();
        wr(`TNE_OFS_CTRL, 32'h0001_0001);
        key(8'h64);
        ntf_q.push_back(8'h64);
        dig(9);
        key(`TNE_K_BUZZ);
        key(`TNE_K_MENU);
        drain();
        chk(39'(menus), 39'h1);
        for (int i = 0; i < 9; i++)
            dig($urandom % 10);
        dig(12);
        conf(1'h1, 1'h0);
        drain();
        wr(`TNE_OFS_CTRL, 32'h0001_0003);
        hx = 1;
        for (int i = 0; i < 9; i++)
            dig($urandom % 16);
        conf(1'h1, 1'h0);
        drain();
        wr(`TNE_OFS_CTRL, 32'h0001_0005);
        hx = 0;
        lim = 7;
        key(`TNE_K_SIGN);
        for (int i = 0; i < 9; i++)
            dig($urandom % 10);
        conf(1'h1, 1'h1);
        drain();
        lim = 8;
        wr(`TNE_OFS_UPPER, 32'h0000_0050);
        wr(`TNE_OFS_LOWER, 32'h0000_0000);
        wr(`TNE_OFS_CTRL, 32'h0001_0009);
        dig(9);
        dig(9);
        conf(1'h1, 1'h0);
        wr(`TNE_OFS_CTRL, 32'h0001_0019);
        dig(9);
        dig(9);
        conf(1'h0, 1'h0);
        dig(4);
        dig(2);
        conf(1'h1, 1'h0);
        drain();
        wr(`TNE_OFS_SEL, 32'h0);
        rdr(`TNE_OFS_DATA);
        chk(39'(rd), 39'h42);
        wr(`TNE_OFS_CTRL, 32'h0001_0051);
        wheel(1'h1, 3'h0);
        exp_q.push_back({1'h0, 6'h00, 32'h43});
        wheel(1'h0, 3'h1);
        exp_q.push_back({1'h0, 6'h00, 32'h33});
        drain();
        wr(`TNE_OFS_BUZZ, 32'h1);
        chk(39'(buzzer_on), 39'h1);
        key(`TNE_K_BUZZ);
        rdr(`TNE_OFS_BUZZ);
        chk(39'({rd[0], buzzer_on}), 39'h0);
        print_verdict();
    end
endmodule
